// [common/dspg_gate_if.sv]
// Interface carrying per-port enables from the register file to the gates.
// Assumes one system clock feeds every gate cell.
`timescale 1ns/1ps
interface dspg_gate_if #(parameter int N = 8);
	logic [N-1:0] enable;
	logic [N-1:0] gated_clock;
	modport ctrl (output enable, input gated_clock);
	modport gate (input enable, output gated_clock);
endinterface : dspg_gate_if

// [common/dspg_pkg.sv]
// Package for the deep-sleep port clock gating block: offsets, fields, resets.
// Assumes a plain strobe register port with 32-bit data, byte addresses.
package dspg_pkg;
	localparam int DSPG_ADDR_W = 12;
	localparam int DSPG_DATA_W = 32;
	localparam int DSPG_PORTS = 8;
	// System control base; block decodes only the offset
	localparam logic [31:0] DSPG_BASE = 32'h400f_e000;
	localparam logic [11:0] DSPG_RUN_OFS = 12'h100;
	localparam logic [11:0] DSPG_SLEEP_OFS = 12'h118;
	localparam logic [11:0] DSPG_DEEP_OFS = 12'h128;
	localparam logic [11:0] DSPG_CFG_OFS = 12'h060;
	localparam logic [11:0] DSPG_STAT_OFS = 12'h1f0;
	// Configuration word field positions
	localparam int DSPG_AUTO_GATE_BIT = 0;
	// Status word field positions
	localparam int DSPG_STAT_SLEEP_BIT = 0;
	localparam int DSPG_STAT_DEEP_BIT = 1;
	localparam int DSPG_STAT_ACT_LSB = 8;
	// Reset values
	localparam logic [7:0] DSPG_GATE_RST = 8'h00;
	localparam logic DSPG_AUTO_GATE_RST = 1'b0;
	localparam logic [31:0] DSPG_ZERO = 32'h0000_0000;
	typedef enum logic [1:0] {DSPG_RUN, DSPG_SLEEP, DSPG_DEEP} dspg_mode_t;
endpackage : dspg_pkg

// [core/dspg_clock_gate.sv]
// Glitch-free clock gates, one per port.
// Assumes enables change only just after a rising clock edge.
`timescale 1ns/1ps
module dspg_clock_gate #(
	parameter int N = 8
) (
	// Clock
	input wire logic clock,
	// Enables in, gated clocks out
	dspg_gate_if.gate gif
);
	genvar i;
	// One latch-based gate per port
	for (i = 0; i < N; i++) begin : g_gate
		logic en_latch;
		// [RULE10] Latch open while low
		always_latch begin
			if (!clock) begin
				en_latch <= gif.enable[i];
			end
		end
		// [RULE2] Clock passes when enabled
		assign gif.gated_clock[i] = clock & en_latch;
	end
endmodule : dspg_clock_gate

// [core/dspg_top.sv]
// Deep-sleep port clock gating: three gating words, mode select, fault check.
// Assumes the power controller supplies the sleep and deep-sleep levels on
// the system clock, and that each port bus access is flagged by its select.
//
// How it works
// [RULE1] Bits 7..0 gate ports A..H, one enable bit per port.
// [RULE2] Enable bit one passes that port's clock.
// [RULE3] Enable bit zero withholds the clock, port disabled.
// [RULE4] Access to a port with clock off answers with bus fault.
// [RULE5] Reset clears the deep-sleep word to all zeros.
// [RULE6] Separate run, sleep, deep-sleep words; deep word only in deep sleep.
// [RULE7] Sleep words apply only when auto clock gating bit is set.
// [RULE8] Bits 31..8 read zero and ignore writes.
// [RULE9] Deep-sleep word decoded at offset 0x128 from system control base.
// [RULE10] Latch-based gates switch clocks without truncated pulses.
//
// The plain strobed port is this design's own decision.
`timescale 1ns/1ps
module dspg_top #(
	parameter int PORTS = dspg_pkg::DSPG_PORTS
) (
	// Clock, reset, enable
	input wire logic clock,
	input wire logic reset_n,
	input wire logic clk_en,
	// Register port
	input wire logic [dspg_pkg::DSPG_ADDR_W-1:0] reg_addr,
	input wire logic [dspg_pkg::DSPG_DATA_W-1:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	output logic [dspg_pkg::DSPG_DATA_W-1:0] reg_rdata,
	// Power state from the power controller
	input wire logic sleep_req,
	input wire logic deep_sleep_req,
	// Port bus accesses and their faults
	input wire logic [PORTS-1:0] port_access,
	output logic [PORTS-1:0] port_fault,
	// Gated clocks and enables to the ports
	output logic [PORTS-1:0] port_clock,
	output logic [PORTS-1:0] port_clock_on
);
	import dspg_pkg::*;

	// Port count must fit the low byte of the gating words
	if (PORTS < 1 || PORTS > 8) begin : g_bad_ports
		$error("PORTS must be 1 to 8");
	end

	typedef struct packed {
		logic [PORTS-1:0] run_gate;
		logic [PORTS-1:0] sleep_gate;
		logic [PORTS-1:0] deep_gate;
		logic auto_gate;
		dspg_mode_t mode;
		logic [PORTS-1:0] active;
		logic [PORTS-1:0] fault;
		logic [DSPG_DATA_W-1:0] rdata;
	} dspg_state_t;

	dspg_state_t state_reg;
	dspg_state_t state_next;
	logic [PORTS-1:0] chosen;
	logic [DSPG_DATA_W-1:0] rd_word;

	dspg_gate_if #(.N(PORTS)) gif ();

	// Read mux; reserved and unmapped bits read zero
	always_comb begin
		rd_word = DSPG_ZERO;
		unique case (reg_addr)
			DSPG_RUN_OFS: rd_word[PORTS-1:0] = state_reg.run_gate;
			DSPG_SLEEP_OFS: rd_word[PORTS-1:0] = state_reg.sleep_gate;
			// [RULE9] Deep word offset
			DSPG_DEEP_OFS: rd_word[PORTS-1:0] = state_reg.deep_gate;
			DSPG_CFG_OFS: rd_word[DSPG_AUTO_GATE_BIT] = state_reg.auto_gate;
			DSPG_STAT_OFS: begin
				rd_word[DSPG_STAT_SLEEP_BIT] = (state_reg.mode == DSPG_SLEEP);
				rd_word[DSPG_STAT_DEEP_BIT] = (state_reg.mode == DSPG_DEEP);
				rd_word[DSPG_STAT_ACT_LSB +: PORTS] = state_reg.active;
			end
			default: rd_word = DSPG_ZERO;
		endcase
	end

	// Word chosen by current mode
	always_comb begin
		unique case (state_reg.mode)
			DSPG_RUN: chosen = state_reg.run_gate;
			DSPG_SLEEP: chosen = state_reg.sleep_gate;
			// [RULE6] Deep word in deep sleep
			DSPG_DEEP: chosen = state_reg.deep_gate;
			default: chosen = state_reg.run_gate;
		endcase
	end

	// Next state
	always_comb begin
		state_next = state_reg;
		state_next.rdata = DSPG_ZERO;
		if (reg_read) begin
			state_next.rdata = rd_word;
		end
		if (reg_write) begin
			unique case (reg_addr)
				DSPG_RUN_OFS: state_next.run_gate = reg_wdata[PORTS-1:0];
				DSPG_SLEEP_OFS: state_next.sleep_gate = reg_wdata[PORTS-1:0];
				// [RULE8] Upper bits dropped
				DSPG_DEEP_OFS: state_next.deep_gate = reg_wdata[PORTS-1:0];
				DSPG_CFG_OFS: state_next.auto_gate = reg_wdata[DSPG_AUTO_GATE_BIT];
				default: ;
			endcase
		end
		// [RULE7] Sleep modes need auto gating
		if (!state_reg.auto_gate) begin
			state_next.mode = DSPG_RUN;
		end else if (deep_sleep_req) begin
			state_next.mode = DSPG_DEEP;
		end else if (sleep_req) begin
			state_next.mode = DSPG_SLEEP;
		end else begin
			state_next.mode = DSPG_RUN;
		end
		// [RULE2] Active set follows mode word
		state_next.active = chosen;
		// [RULE4] Fault on gated port access
		state_next.fault = port_access & ~state_reg.active;
	end

	// State register; clock enable freezes all
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			state_reg.run_gate <= '0;
			state_reg.sleep_gate <= '0;
			// [RULE5] Cleared on reset
			state_reg.deep_gate <= '0;
			state_reg.auto_gate <= DSPG_AUTO_GATE_RST;
			state_reg.mode <= DSPG_RUN;
			state_reg.active <= '0;
			state_reg.fault <= '0;
			state_reg.rdata <= DSPG_ZERO;
		end else if (clk_en) begin
			state_reg <= state_next;
		end
	end

	// [RULE3] Gates fed from registered set
	assign gif.enable = state_reg.active;
	dspg_clock_gate #(.N(PORTS)) u_gate (
		.clock(clock),
		.gif(gif.gate)
	);

	assign port_clock = gif.gated_clock;
	assign port_clock_on = state_reg.active;
	assign port_fault = state_reg.fault;
	assign reg_rdata = state_reg.rdata;

	// Assertions
	property p_deep_fault;
		@(posedge clock) disable iff (!reset_n)
		(clk_en && port_access[0] && !state_reg.active[0]) |=> port_fault[0];
	endproperty
	a_deep_fault: assert property (p_deep_fault) else $error("no fault"); // [RULE4]

	property p_no_fault;
		@(posedge clock) disable iff (!reset_n)
		(clk_en && state_reg.active[0]) |=> !port_fault[0];
	endproperty
	a_no_fault: assert property (p_no_fault) else $error("spurious fault"); // [RULE4]

	sequence s_wr_deep;
		clk_en && reg_write && reg_addr == DSPG_DEEP_OFS;
	endsequence
	sequence s_rd_deep;
		clk_en && reg_read && reg_addr == DSPG_DEEP_OFS && !reg_write;
	endsequence
	property p_deep_rw;
		logic [7:0] v;
		@(posedge clock) disable iff (!reset_n)
		(s_wr_deep, v = reg_wdata[7:0]) ##1 s_rd_deep |=> reg_rdata == {24'h000000, v};
	endproperty
	a_deep_rw: assert property (p_deep_rw) else $error("deep word readback"); // [RULE9]

	property p_upper_zero;
		@(posedge clock) disable iff (!reset_n)
		1'b1 |-> reg_rdata[31:16] == 16'h0000;
	endproperty
	a_upper_zero: assert property (p_upper_zero) else $error("reserved bits set"); // [RULE8]

	property p_gate_upper_zero;
		@(posedge clock) disable iff (!reset_n)
		(clk_en && reg_read && reg_addr == DSPG_DEEP_OFS) |=> reg_rdata[31:8] == 24'h000000;
	endproperty
	a_gate_upper_zero: assert property (p_gate_upper_zero) else $error("gate word upper bits"); // [RULE8]

	property p_deep_applies;
		@(posedge clock) disable iff (!reset_n)
		(clk_en && state_reg.mode == DSPG_DEEP) |=> port_clock_on == $past(state_reg.deep_gate);
	endproperty
	a_deep_applies: assert property (p_deep_applies) else $error("deep word unused"); // [RULE6]

	property p_auto_off_run;
		@(posedge clock) disable iff (!reset_n)
		(clk_en && !state_reg.auto_gate) |=> state_reg.mode == DSPG_RUN;
	endproperty
	a_auto_off_run: assert property (p_auto_off_run) else $error("sleep without auto gating"); // [RULE7]

	property p_deep_enter;
		@(posedge clock) disable iff (!reset_n)
		(clk_en && state_reg.auto_gate && deep_sleep_req) |=> state_reg.mode == DSPG_DEEP;
	endproperty
	a_deep_enter: assert property (p_deep_enter) else $error("deep not entered"); // [RULE6]

	// Sampled on the falling edge, where a gated clock shows its latched enable;
	// the latch closes at the rising edge, so the gate lags the enable one cycle
	property p_off_no_clock;
		@(negedge clock) disable iff (!reset_n)
		!port_clock_on[0] |=> !port_clock[0];
	endproperty
	a_off_no_clock: assert property (p_off_no_clock) else $error("clock leaks"); // [RULE3]

	property p_on_clock;
		@(negedge clock) disable iff (!reset_n)
		port_clock_on[0] |=> port_clock[0];
	endproperty
	a_on_clock: assert property (p_on_clock) else $error("clock missing"); // [RULE2]

	property p_reset_zero;
		@(posedge clock)
		$rose(reset_n) |-> state_reg.deep_gate == 8'h00 && port_clock_on == 8'h00;
	endproperty
	a_reset_zero: assert property (p_reset_zero) else $error("reset not zero"); // [RULE5]
endmodule : dspg_top

// [dv/dspg_tb.sv]
// Self-checking bench for the deep-sleep port clock gating block.
// Assumes dspg_pkg, the gate interface and the core files are compiled first.
`timescale 1ns/1ps
module testbench;
	import dspg_pkg::*;
	logic clock = 1'b0;
	logic reset_n = 1'b0;
	logic clk_en = 1'b1;
	logic [DSPG_ADDR_W-1:0] reg_addr = 12'h000;
	logic [DSPG_DATA_W-1:0] reg_wdata = 32'h0;
	logic reg_write = 1'b0;
	logic reg_read = 1'b0;
	logic [DSPG_DATA_W-1:0] reg_rdata;
	logic sleep_req = 1'b0;
	logic deep_sleep_req = 1'b0;
	logic [7:0] port_access = 8'h00;
	logic [7:0] port_fault;
	logic [7:0] port_clock;
	logic [7:0] port_clock_on;
	int num_errors = 0;
	int checks_done = 0;

	// 40 MHz system clock
	always #12.5 clock = ~clock;

	dspg_top dspg_top_i (.clock(clock), .reset_n(reset_n), .clk_en(clk_en),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
		.reg_read(reg_read), .reg_rdata(reg_rdata), .sleep_req(sleep_req),
		.deep_sleep_req(deep_sleep_req), .port_access(port_access),
		.port_fault(port_fault), .port_clock(port_clock), .port_clock_on(port_clock_on));

	// Case inequality so an unknown never passes
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			num_errors++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : cmp

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		@(posedge clock);
		reg_addr <= a;
		reg_wdata <= d;
		reg_write <= 1'b1;
		@(posedge clock);
		reg_write <= 1'b0;
	endtask : wr

	// Read data stands only in the cycle after the strobe
	task automatic rd_cmp(input logic [11:0] a, input logic [31:0] exp);
		@(posedge clock);
		reg_addr <= a;
		reg_read <= 1'b1;
		@(posedge clock);
		reg_read <= 1'b0;
		#1 cmp(reg_rdata, exp);
	endtask : rd_cmp

	// Write then read with no gap; read data taken in the cycle it stands
	task automatic wr_rd_cmp(input logic [11:0] a, input logic [31:0] d,
		input logic [31:0] exp);
		@(posedge clock);
		reg_addr <= a;
		reg_wdata <= d;
		reg_write <= 1'b1;
		@(posedge clock);
		reg_write <= 1'b0;
		reg_read <= 1'b1;
		@(posedge clock);
		reg_read <= 1'b0;
		#1 cmp(reg_rdata, exp);
	endtask : wr_rd_cmp

	task automatic access_cmp(input logic [7:0] acc, input logic [7:0] exp);
		@(posedge clock);
		port_access <= acc;
		@(posedge clock);
		port_access <= 8'h00;
		#1 cmp({24'h0, port_fault}, {24'h0, exp});
	endtask : access_cmp

	// Gated clocks follow the clock while high, stay low in the low phase
	task automatic clk_cmp(input logic [7:0] exp);
		@(posedge clock);
		#5 cmp({24'h0, port_clock_on}, {24'h0, exp});
		cmp({24'h0, port_clock}, {24'h0, exp});
		#13 cmp({24'h0, port_clock}, 32'h0);
	endtask : clk_cmp

	task automatic mode_wait(input logic s, input logic d);
		@(posedge clock);
		sleep_req <= s;
		deep_sleep_req <= d;
		repeat (4) @(posedge clock);
	endtask : mode_wait

	task automatic test_reset;
		rd_cmp(DSPG_DEEP_OFS, DSPG_ZERO);
		clk_cmp(8'h00);
		access_cmp(8'hff, 8'hff);
		$display("test_reset done");
	endtask : test_reset

	task automatic test_fields;
		wr(DSPG_DEEP_OFS, 32'hffff_ffff);
		rd_cmp(DSPG_DEEP_OFS, 32'h0000_00ff);
		wr_rd_cmp(DSPG_DEEP_OFS, 32'h1234_565a, 32'h0000_005a);
		wr(DSPG_DEEP_OFS, 32'h0000_0005);
		rd_cmp(DSPG_DEEP_OFS, 32'h0000_0005);
		rd_cmp(12'h124, DSPG_ZERO);
		$display("test_fields done");
	endtask : test_fields

	task automatic test_modes;
		wr(DSPG_RUN_OFS, 32'h0000_00a0);
		wr(DSPG_SLEEP_OFS, 32'h0000_0030);
		wr(DSPG_CFG_OFS, 32'h0000_0001);
		rd_cmp(DSPG_RUN_OFS, 32'h0000_00a0);
		rd_cmp(DSPG_SLEEP_OFS, 32'h0000_0030);
		rd_cmp(DSPG_CFG_OFS, 32'h0000_0001);
		mode_wait(1'b0, 1'b0);
		clk_cmp(8'ha0);
		mode_wait(1'b0, 1'b1);
		clk_cmp(8'h05);
		access_cmp(8'hff, 8'hfa);
		access_cmp(8'h05, 8'h00);
		// Status: deep flag in bit 1, active set in bits 15..8
		rd_cmp(DSPG_STAT_OFS, 32'h0000_0502);
		mode_wait(1'b1, 1'b0);
		clk_cmp(8'h30);
		rd_cmp(DSPG_STAT_OFS, 32'h0000_3001);
		wr(DSPG_CFG_OFS, 32'h0000_0000);
		mode_wait(1'b0, 1'b1);
		clk_cmp(8'ha0);
		rd_cmp(DSPG_STAT_OFS, 32'h0000_a000);
		mode_wait(1'b0, 1'b0);
		$display("test_modes done");
	endtask : test_modes

	// Reset in mid-run must clear a written word
	task automatic test_mid_reset;
		wr(DSPG_DEEP_OFS, 32'h0000_005a);
		@(posedge clock);
		reset_n <= 1'b0;
		repeat (2) @(posedge clock);
		reset_n <= 1'b1;
		rd_cmp(DSPG_DEEP_OFS, DSPG_ZERO);
		$display("test_mid_reset done");
	endtask : test_mid_reset

	// Low clock enable must hold every register, a write included
	task automatic test_freeze;
		wr(DSPG_DEEP_OFS, 32'h0000_0011);
		@(posedge clock);
		clk_en <= 1'b0;
		wr(DSPG_DEEP_OFS, 32'h0000_0033);
		@(posedge clock);
		clk_en <= 1'b1;
		rd_cmp(DSPG_DEEP_OFS, 32'h0000_0011);
		$display("test_freeze done");
	endtask : test_freeze

	task automatic wrap_up;
		$display("checks=%0d errors=%0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : wrap_up

	initial begin
		repeat (8) @(posedge clock);
		reset_n <= 1'b1;
		test_reset();
		test_fields();
		test_modes();
		test_mid_reset();
		test_freeze();
		wrap_up();
	end

	// Tests need about 95 cycles; this limit is far beyond that
	initial begin
		#20us;
		num_errors++;
		wrap_up();
	end
endmodule : testbench
